// File: verilog/lss_pkg.sv
// Shared constants for the linear sensor scan timing pair.
// Assumes both ends run on one 200 MHz system clock.
package lss_pkg;

	// System clock and line rate
	localparam int unsigned SYS_CLK_HZ     = 200_000_000;
	localparam int unsigned PIXEL_RATE_MAX = 10_000_000;
	localparam int unsigned LCLK_DIV       = SYS_CLK_HZ / PIXEL_RATE_MAX;
	localparam int unsigned LCLK_HALF      = LCLK_DIV / 2;

	// Pixel and sample widths
	localparam int unsigned PIX_W          = 12;
	localparam int unsigned IDX_W          = 11;
	localparam int unsigned CNT_W          = 12;
	localparam int unsigned LEN_W          = 16;
	localparam int unsigned DIV_W          = 5;

	// Scan geometry, counted in capture strobes
	localparam logic [CNT_W-1:0] PIX_COUNT     = 12'h800;
	localparam logic [CNT_W-1:0] FIRST_VALID   = 12'h059;
	localparam logic [CNT_W-1:0] LAST_STROBE   = FIRST_VALID + PIX_COUNT - 12'h001;
	localparam logic [CNT_W-1:0] IDX_OFFSET    = FIRST_VALID - 12'h001;

	// Start pulse limits and integration tail, in line clock periods
	localparam logic [LEN_W-1:0] START_HIGH_MIN = 16'h0006;
	localparam logic [LEN_W-1:0] START_LOW_MIN  = 16'h0064;
	localparam logic [LEN_W-1:0] INTEG_TAIL     = 16'h0030;

	// Reset values
	localparam logic [PIX_W-1:0] PIX_RST        = 12'h000;
	localparam logic [LEN_W-1:0] LEN_RST        = 16'h0000;

	// Controller start pulse sequencer
	typedef enum logic [1:0] {
		LSS_ST_IDLE = 2'b00,
		LSS_ST_HIGH = 2'b01,
		LSS_ST_LOW  = 2'b10
	} lss_start_state_t;

endpackage : lss_pkg

// File: verilog/lss_link_if.sv
// Link between the scan controller and the sensor timing generator.
// The testbench instantiates it and joins the two ends.
`timescale 1ns/1ps
`default_nettype none
interface lss_link_if;
	// Controller to sensor
	logic                      line_clk;
	logic                      scan_start_pulse;
	// Sensor to controller
	logic                      capture_strobe;
	logic                      scan_done_flag;
	logic [lss_pkg::PIX_W-1:0] pixel_data;

	modport sensor (
		input  line_clk,
		input  scan_start_pulse,
		output capture_strobe,
		output scan_done_flag,
		output pixel_data
	);

	modport ctrl (
		output line_clk,
		output scan_start_pulse,
		input  capture_strobe,
		input  scan_done_flag,
		input  pixel_data
	);
endinterface : lss_link_if
`default_nettype wire

// File: verilog/lss_ctrl.sv
// Scan controller: makes the line clock and start pulse, captures pixels.
// Assumes the sensor end answers on the same link interface.
`timescale 1ns/1ps
`default_nettype none
module lss_ctrl (
	// Clock and reset
	input  wire logic                      sys_clk,
	input  wire logic                      sys_rst,
	// Link
	lss_link_if.ctrl                       link,
	// Scan settings
	input  wire logic                      run,
	input  wire logic [lss_pkg::LEN_W-1:0] start_high_length,
	input  wire logic [lss_pkg::LEN_W-1:0] start_low_length,
	// Captured pixels
	output logic                           pix_valid,
	output logic [lss_pkg::PIX_W-1:0]      pix_data,
	output logic [lss_pkg::IDX_W-1:0]      pix_index,
	output logic                           scan_end,
	output logic                           scan_usable
);

	// Clamp a requested length to its floor
	function automatic logic [lss_pkg::LEN_W-1:0] clamp_len(
		input logic [lss_pkg::LEN_W-1:0] req,
		input logic [lss_pkg::LEN_W-1:0] floor_len);
		clamp_len = (req < floor_len) ? floor_len : req;
	endfunction : clamp_len

	logic [lss_pkg::DIV_W-1:0]  div_reg, div_next;
	logic                       lclk_reg, lclk_next;
	logic                       start_reg, start_next;
	lss_pkg::lss_start_state_t  state_reg, state_next;
	logic [lss_pkg::LEN_W-1:0]  ph_reg, ph_next;
	logic                       tick_fall;

	// one pixel per line clock, at most 10 MHz
	assign tick_fall = (div_reg == lss_pkg::DIV_W'(lss_pkg::LCLK_HALF - 1));

	always_comb begin
		div_next   = (div_reg == lss_pkg::DIV_W'(lss_pkg::LCLK_DIV - 1)) ?
			'0 : div_reg + 1'b1;
		lclk_next  = (div_next < lss_pkg::DIV_W'(lss_pkg::LCLK_HALF));
		start_next = start_reg;
		state_next = state_reg;
		ph_next    = ph_reg;
		// Start only moves at a line clock falling edge, well away from rising edges
		if (tick_fall) begin
			case (state_reg)
				lss_pkg::LSS_ST_IDLE: begin
					if (run) begin
						start_next = 1'b1;
						ph_next    = 16'h0001;
						state_next = lss_pkg::LSS_ST_HIGH;
					end
				end
				lss_pkg::LSS_ST_HIGH: begin
					if (ph_reg >= clamp_len(start_high_length, lss_pkg::START_HIGH_MIN)) begin
						start_next = 1'b0;
						ph_next    = 16'h0001;
						state_next = lss_pkg::LSS_ST_LOW;
					end else begin
						ph_next = ph_reg + 1'b1;
					end
				end
				lss_pkg::LSS_ST_LOW: begin
					if (ph_reg >= clamp_len(start_low_length, lss_pkg::START_LOW_MIN)) begin
						ph_next    = 16'h0001;
						start_next = run;
						state_next = run ? lss_pkg::LSS_ST_HIGH : lss_pkg::LSS_ST_IDLE;
					end else begin
						ph_next = ph_reg + 1'b1;
					end
				end
				default: begin
					start_next = 1'b0;
					state_next = lss_pkg::LSS_ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			// Last count of the low half, so the first line clock high lasts a full half period
			div_reg   <= lss_pkg::DIV_W'(lss_pkg::LCLK_DIV - 1);
			lclk_reg  <= 1'b0;
			start_reg <= 1'b0;
			state_reg <= lss_pkg::LSS_ST_IDLE;
			ph_reg    <= lss_pkg::LEN_RST;
		end else begin
			div_reg   <= div_next;
			lclk_reg  <= lclk_next;
			start_reg <= start_next;
			state_reg <= state_next;
			ph_reg    <= ph_next;
		end
	end

	assign link.line_clk         = lclk_reg;
	assign link.scan_start_pulse = start_reg;

	// Sensor outputs arrive from outside: two flops before use
	logic [lss_pkg::PIX_W-1:0] data_s1, data_s2;
	logic                      stb_s1, stb_s2, stb_s3;
	logic                      done_s1, done_s2, done_s3;
	logic [lss_pkg::CNT_W-1:0] scnt_reg, scnt_next;
	logic                      cap_reg, cap_next;
	logic                      seen_reg, seen_next;
	logic                      pv_next, end_next;
	logic [lss_pkg::PIX_W-1:0] pd_next;
	logic [lss_pkg::IDX_W-1:0] pi_next;

	always_comb begin
		scnt_next = scnt_reg;
		cap_next  = cap_reg;
		seen_next = seen_reg;
		pv_next   = 1'b0;
		end_next  = 1'b0;
		pd_next   = pix_data;
		pi_next   = pix_index;
		// end of scan stops capture
		// A start fall in the same cycle re-arms capture below, so the set wins
		if (done_s2 && !done_s3) begin
			cap_next  = 1'b0;
			seen_next = 1'b1;
			end_next  = 1'b1;
		end
		if (start_reg && !start_next) begin
			scnt_next = '0;
			cap_next  = 1'b1;
		end else if (cap_reg && stb_s2 && !stb_s3) begin
			scnt_next = scnt_reg + 1'b1;
			if (scnt_next >= lss_pkg::FIRST_VALID && scnt_next <= lss_pkg::LAST_STROBE) begin
				pv_next = seen_reg;
				pd_next = data_s2;
				pi_next = lss_pkg::IDX_W'(scnt_next - lss_pkg::FIRST_VALID);
			end
			if (scnt_next == lss_pkg::LAST_STROBE)
				cap_next = 1'b0;
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			data_s1   <= lss_pkg::PIX_RST;
			data_s2   <= lss_pkg::PIX_RST;
			{stb_s1, stb_s2, stb_s3}    <= 3'h0;
			{done_s1, done_s2, done_s3} <= 3'h0;
			scnt_reg  <= '0;
			cap_reg   <= 1'b0;
			seen_reg  <= 1'b0;
			pix_valid <= 1'b0;
			pix_data  <= lss_pkg::PIX_RST;
			pix_index <= '0;
			scan_end  <= 1'b0;
		end else begin
			data_s1   <= link.pixel_data;
			data_s2   <= data_s1;
			{stb_s1, stb_s2, stb_s3}    <= {link.capture_strobe, stb_s1, stb_s2};
			{done_s1, done_s2, done_s3} <= {link.scan_done_flag, done_s1, done_s2};
			scnt_reg  <= scnt_next;
			cap_reg   <= cap_next;
			seen_reg  <= seen_next;
			pix_valid <= pv_next;
			pix_data  <= pd_next;
			pix_index <= pi_next;
			scan_end  <= end_next;
		end
	end

	assign scan_usable = seen_reg;

endmodule : lss_ctrl
`default_nettype wire

// File: verilog/lss_sensor.sv
// Sensor end: internal timing generator of a 2048-pixel linear sensor.
// Assumes line clock and start come from the controller end as pins.
`timescale 1ns/1ps
`default_nettype none
module lss_sensor (
	// Clock and reset
	input  wire logic                      sys_clk,
	input  wire logic                      sys_rst,
	// Link
	lss_link_if.sensor                     link,
	// Pixel source
	output logic [lss_pkg::IDX_W-1:0]      pixel_sel,
	input  wire logic [lss_pkg::PIX_W-1:0] pixel_value,
	// Status
	output logic                           integrating,
	output logic [lss_pkg::LEN_W-1:0]      integ_length,
	output logic                           scan_invalid
);

	// Pin synchronisers
	logic lclk_s1, lclk_s2, lclk_s3;
	logic st_s1, st_s2, st_s3;
	logic lclk_rise, lclk_fall;
	logic st_rise, st_fall;

	assign lclk_rise = lclk_s2 && !lclk_s3;
	assign lclk_fall = !lclk_s2 && lclk_s3;
	assign st_rise   = st_s2 && !st_s3;
	assign st_fall   = !st_s2 && st_s3;

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			{lclk_s1, lclk_s2, lclk_s3} <= 3'h0;
			{st_s1, st_s2, st_s3}       <= 3'h0;
		end else begin
			{lclk_s1, lclk_s2, lclk_s3} <= {link.line_clk, lclk_s1, lclk_s2};
			{st_s1, st_s2, st_s3}       <= {link.scan_start_pulse, st_s1, st_s2};
		end
	end

	// Readout state
	logic                      reading_reg, reading_next;
	logic                      fell_reg, fell_next;
	logic [lss_pkg::CNT_W-1:0] cnt_reg, cnt_next;
	logic                      strobe_reg, strobe_next;
	logic [lss_pkg::PIX_W-1:0] data_reg, data_next;
	logic                      done_reg, done_next;
	logic                      first_reg, first_next;

	// Next strobe is cnt_reg + 1, so its pixel is cnt_reg - 88
	assign pixel_sel = lss_pkg::IDX_W'(cnt_reg - lss_pkg::IDX_OFFSET);

	always_comb begin
		reading_next = reading_reg;
		fell_next    = fell_reg;
		cnt_next     = cnt_reg;
		strobe_next  = strobe_reg;
		data_next    = data_reg;
		done_next    = done_reg;
		first_next   = first_reg;
		// Falling start is remembered until the next line clock rise
		if (st_fall)
			fell_next = 1'b1;
		if (lclk_fall)
			strobe_next = 1'b0;
		if (lclk_rise) begin
			// Done lasts exactly one line clock period
			done_next = 1'b0;
			if (fell_reg || st_fall) begin
				fell_next    = 1'b0;
				reading_next = 1'b1;
				cnt_next     = 12'h001;
				strobe_next  = 1'b1;
				data_next    = lss_pkg::PIX_RST;
			end else if (reading_reg) begin
				if (cnt_reg == lss_pkg::LAST_STROBE) begin
					// one end pulse after last pixel
					reading_next = 1'b0;
					done_next    = 1'b1;
					first_next   = 1'b0;
					data_next    = lss_pkg::PIX_RST;
				end else begin
					cnt_next    = cnt_reg + 1'b1;
					strobe_next = 1'b1;
					if (cnt_next >= lss_pkg::FIRST_VALID) begin
						data_next = first_reg ? ~pixel_value : pixel_value;
					end else begin
						data_next = lss_pkg::PIX_RST;
					end
				end
			end
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			reading_reg <= 1'b0;
			fell_reg    <= 1'b0;
			cnt_reg     <= '0;
			strobe_reg  <= 1'b0;
			data_reg    <= lss_pkg::PIX_RST;
			done_reg    <= 1'b0;
			first_reg   <= 1'b1;
		end else begin
			reading_reg <= reading_next;
			fell_reg    <= fell_next;
			cnt_reg     <= cnt_next;
			strobe_reg  <= strobe_next;
			data_reg    <= data_next;
			done_reg    <= done_next;
			first_reg   <= first_next;
		end
	end

	assign link.capture_strobe = strobe_reg;
	assign link.pixel_data     = data_reg;
	assign link.scan_done_flag = done_reg;
	assign scan_invalid        = first_reg;

	// Integration tracking, in line clock periods
	logic                      integ_reg, integ_next;
	logic [lss_pkg::LEN_W-1:0] icnt_reg, icnt_next;
	logic [lss_pkg::LEN_W-1:0] tail_reg, tail_next;
	logic [lss_pkg::LEN_W-1:0] ilen_reg, ilen_next;

	always_comb begin
		integ_next = integ_reg;
		icnt_next  = icnt_reg;
		tail_next  = tail_reg;
		ilen_next  = ilen_reg;
		if (st_rise) begin
			integ_next = 1'b1;
			icnt_next  = lss_pkg::LEN_RST;
			tail_next  = lss_pkg::LEN_RST;
		end else if (lclk_rise && integ_reg) begin
			icnt_next = icnt_reg + 1'b1;
			if (!st_s2) begin
				tail_next = tail_reg + 1'b1;
				if (tail_next == lss_pkg::INTEG_TAIL) begin
					integ_next = 1'b0;
					ilen_next  = icnt_next;
				end
			end
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			integ_reg <= 1'b0;
			icnt_reg  <= lss_pkg::LEN_RST;
			tail_reg  <= lss_pkg::LEN_RST;
			ilen_reg  <= lss_pkg::LEN_RST;
		end else begin
			integ_reg <= integ_next;
			icnt_reg  <= icnt_next;
			tail_reg  <= tail_next;
			ilen_reg  <= ilen_next;
		end
	end

	assign integrating  = integ_reg;
	assign integ_length = ilen_reg;

endmodule : lss_sensor
`default_nettype wire

// File: tb/lss_checker.sv
// Link checker for the scan controller and sensor pair.
// Assumes it is wired by name to the link interface signals.
`timescale 1ns/1ps
`default_nettype none
module lss_checker (
	// Clock and reset
	input  wire logic                      sys_clk,
	input  wire logic                      sys_rst,
	// Link
	input  wire logic                      line_clk,
	input  wire logic                      scan_start_pulse,
	input  wire logic                      capture_strobe,
	input  wire logic                      scan_done_flag,
	input  wire logic [lss_pkg::PIX_W-1:0] pixel_data
);
	logic [11:0] stb_cnt_reg;
	logic [11:0] stb_cnt_next;
	logic [15:0] hi_cnt_reg;
	logic [15:0] hi_cnt_next;
	logic [15:0] lo_cnt_reg;
	logic [15:0] lo_cnt_next;
	logic        line_d_reg;
	logic        st_d_reg;
	logic        stb_d_reg;
	logic        seen_done_reg;
	logic        seen_fall_reg;

	always_comb begin
		stb_cnt_next = stb_cnt_reg;
		hi_cnt_next = hi_cnt_reg;
		lo_cnt_next = lo_cnt_reg;
		if (capture_strobe && !stb_d_reg) begin
			stb_cnt_next = stb_cnt_reg + 12'h001;
		end
		// Strobe numbering restarts at every start fall
		if (!scan_start_pulse && st_d_reg) begin
			stb_cnt_next = 12'h000;
		end
		if (line_clk && !line_d_reg) begin
			hi_cnt_next = scan_start_pulse ? hi_cnt_reg + 16'h0001 : 16'h0000;
			lo_cnt_next = scan_start_pulse ? 16'h0000 : lo_cnt_reg + 16'h0001;
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			stb_cnt_reg <= 12'h000;
			hi_cnt_reg <= 16'h0000;
			lo_cnt_reg <= 16'h0000;
			line_d_reg <= 1'b0;
			st_d_reg <= 1'b0;
			stb_d_reg <= 1'b0;
			seen_done_reg <= 1'b0;
			seen_fall_reg <= 1'b0;
		end else begin
			stb_cnt_reg <= stb_cnt_next;
			hi_cnt_reg <= hi_cnt_next;
			lo_cnt_reg <= lo_cnt_next;
			line_d_reg <= line_clk;
			st_d_reg <= scan_start_pulse;
			stb_d_reg <= capture_strobe;
			seen_done_reg <= seen_done_reg | scan_done_flag;
			seen_fall_reg <= seen_fall_reg | (st_d_reg & !scan_start_pulse);
		end
	end

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (sys_rst);

	a_line_half_period: assert property ($rose(line_clk) |-> ##10 $fell(line_clk) ##10 $rose(line_clk))
		else $error("line clock period wrong");
	a_strobe_rise_lag: assert property ($rose(capture_strobe) |-> $past(line_clk, 3) && !$past(line_clk, 4))
		else $error("strobe not tied to line clock rise");
	a_strobe_fall_lag: assert property ($fell(line_clk) |-> ##3 !capture_strobe)
		else $error("strobe outlived line clock high");
	a_readout_start: assert property ($fell(scan_start_pulse) |-> ##[1:16] $rose(capture_strobe))
		else $error("readout did not start after start fall");
	a_dark_lead: assert property ($rose(capture_strobe) && seen_done_reg && stb_cnt_reg < lss_pkg::IDX_OFFSET
		|-> pixel_data == 12'h000)
		else $error("lead strobe carried pixel data");
	a_first_pixel_live: assert property ($rose(capture_strobe) && seen_done_reg && stb_cnt_reg >= lss_pkg::IDX_OFFSET
		|-> pixel_data != 12'h000)
		else $error("pixel strobe carried no data");
	a_strobe_count_cap: assert property ($rose(capture_strobe) |-> stb_cnt_reg < lss_pkg::LAST_STROBE)
		else $error("too many strobes in scan");
	a_done_after_last: assert property ($rose(scan_done_flag) |-> stb_cnt_reg == lss_pkg::LAST_STROBE)
		else $error("end of scan at wrong strobe count");
	a_done_one_period: assert property ($rose(scan_done_flag)
		|-> scan_done_flag [*8] ##12 scan_done_flag ##1 !scan_done_flag)
		else $error("end of scan width wrong");
	a_start_high_min: assert property ($fell(scan_start_pulse) |-> hi_cnt_reg >= lss_pkg::START_HIGH_MIN)
		else $error("start high too short");
	a_start_low_min: assert property ($rose(scan_start_pulse) && seen_fall_reg
		|-> lo_cnt_reg >= lss_pkg::START_LOW_MIN)
		else $error("start low too short");

	cover property ($fell(scan_start_pulse));
	cover property ($rose(capture_strobe) && stb_cnt_reg == 12'h058);
	cover property ($rose(scan_done_flag) && seen_done_reg);
endmodule : lss_checker
`default_nettype wire

// File: tb/linear_sensor_scan_timing_tb.sv
// Testbench joining the scan controller and sensor over one link.
// Assumes the package, interface and both ends are compiled first.
`timescale 1ns/1ps
`default_nettype none
module linear_sensor_scan_timing_tb;
	logic                      sys_clk = 1'b0;
	logic                      sys_rst = 1'b1;
	logic                      run = 1'b0;
	logic [lss_pkg::LEN_W-1:0] high_len = 16'h0002;
	logic [lss_pkg::LEN_W-1:0] low_len = 16'h085c;
	logic [lss_pkg::IDX_W-1:0] pixel_sel;
	logic [lss_pkg::PIX_W-1:0] pixel_value;
	logic [lss_pkg::PIX_W-1:0] pix_data;
	logic [lss_pkg::IDX_W-1:0] pix_index;
	logic [lss_pkg::LEN_W-1:0] integ_length;
	logic                      pix_valid;
	logic                      scan_end;
	logic                      scan_usable;
	logic                      integrating;
	logic                      scan_invalid;
	logic                      done_d;
	int                        err_count = 0;
	int                        samples_checked = 0;
	int                        pv_cnt = 0;
	int                        done_cnt = 0;
	int                        end_cnt = 0;
	int                        e1 = 0;

	always #2.5 sys_clk = ~sys_clk;
	// Bit 11 always set, so a live pixel is never zero
	assign pixel_value = {1'b1, pixel_sel} ^ 12'h3c5;

	lss_link_if lss_link_if_i ();
	lss_ctrl lss_ctrl_i (
		.sys_clk(sys_clk), .sys_rst(sys_rst), .link(lss_link_if_i), .run(run),
		.start_high_length(high_len), .start_low_length(low_len),
		.pix_valid(pix_valid), .pix_data(pix_data), .pix_index(pix_index),
		.scan_end(scan_end), .scan_usable(scan_usable));
	lss_sensor lss_sensor_i (
		.sys_clk(sys_clk), .sys_rst(sys_rst), .link(lss_link_if_i),
		.pixel_sel(pixel_sel), .pixel_value(pixel_value), .integrating(integrating),
		.integ_length(integ_length), .scan_invalid(scan_invalid));
	lss_checker lss_checker_i (
		.sys_clk(sys_clk), .sys_rst(sys_rst), .line_clk(lss_link_if_i.line_clk),
		.scan_start_pulse(lss_link_if_i.scan_start_pulse),
		.capture_strobe(lss_link_if_i.capture_strobe),
		.scan_done_flag(lss_link_if_i.scan_done_flag), .pixel_data(lss_link_if_i.pixel_data));

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD t=%0t seen %0h expected %0h", $time, seen, exp);
		end
	endtask : check

	task automatic end_sim;
		$display("checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : end_sim

	task automatic wait_done(input int n);
		int k;
		k = 0;
		while (done_cnt < n && k < 50000) begin
			@(posedge sys_clk);
			k++;
		end
		check(32'(done_cnt), 32'(n));
		repeat (40) @(posedge sys_clk);
		#1;
	endtask : wait_done

	always @(posedge sys_clk) begin
		done_d <= lss_link_if_i.scan_done_flag;
		if (lss_link_if_i.scan_done_flag === 1'b1 && done_d === 1'b0) begin
			done_cnt++;
		end
		if (scan_end === 1'b1) begin
			end_cnt++;
		end
		if (pix_valid === 1'b1) begin
			check(32'(pix_index), 32'(pv_cnt[10:0]));
			check(32'(pix_data), 32'({1'b1, pv_cnt[10:0]} ^ 12'h3c5));
			pv_cnt++;
		end
	end

	initial begin
		repeat (20) @(posedge sys_clk);
		#1 sys_rst = 1'b0;
		check(32'(scan_invalid), 32'h1);
		@(posedge sys_clk);
		#1 run = 1'b1;
		wait_done(1);
		check(32'(pv_cnt), 32'h0);
		check(32'(scan_invalid), 32'h0);
		check(32'(scan_usable), 32'h1);
		// short request is raised to six, plus the tail
		check(32'(integ_length), 32'h36);
		check(32'(integrating), 32'h0);
		high_len = 16'h0008;
		e1 = end_cnt;
		$display("test first_scan done");
		wait_done(2);
		check(32'(pv_cnt), 32'h800);
		check(32'(end_cnt - e1), 32'h1);
		check(32'(integ_length), 32'h38);
		$display("test second_scan done");
		end_sim();
	end

	// Two scans take about 86k cycles
	initial begin
		repeat (99000) @(posedge sys_clk);
		err_count++;
		$display("BAD t=%0t watchdog expired", $time);
		end_sim();
	end
endmodule : linear_sensor_scan_timing_tb
`default_nettype wire
